/* include/event_enable_pkg.sv */
package event_enable_pkg;

	localparam int ADDR_W = 8;
	localparam int WORD_W = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_MASK_LOW = 8'h00;
	localparam logic [7:0] OFF_MASK_HIGH = 8'h04;
	localparam logic [7:0] OFF_SET_LOW = 8'h08;
	localparam logic [7:0] OFF_SET_HIGH = 8'h0c;
	localparam logic [7:0] OFF_CLEAR_LOW = 8'h10;
	localparam logic [7:0] OFF_CLEAR_HIGH = 8'h14;

	// Values after reset
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
	localparam logic [63:0] SUBMIT_RESET = 64'h0;

	function automatic logic is_write_only(input logic [7:0] addr);
		is_write_only = (addr == OFF_SET_LOW) || (addr == OFF_SET_HIGH) ||
			(addr == OFF_CLEAR_LOW) || (addr == OFF_CLEAR_HIGH);
	endfunction : is_write_only

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = is_write_only(addr) || (addr == OFF_MASK_LOW) ||
			(addr == OFF_MASK_HIGH);
	endfunction : is_mapped

	function automatic logic [31:0] select_bits(input logic hit,
		input logic [31:0] data);
		select_bits = hit ? data : 32'h0000_0000;
	endfunction : select_bits

endpackage : event_enable_pkg

/* include/mask_update_if.sv */
`timescale 1ns/1ps
interface mask_update_if;
	logic [31:0] set_bits;
	logic [31:0] clr_bits;
	logic [31:0] mask;

	modport owner (input set_bits, input clr_bits, output mask);
	modport user (output set_bits, output clr_bits, input mask);
endinterface : mask_update_if

/* hdl/mask_word.sv */
`timescale 1ns/1ps
module mask_word (
	input wire logic pclk,
	input wire logic presetn,
	mask_update_if.owner port
);
	logic [31:0] mask_reg;
	logic [31:0] mask_next;

	// Ones clear, then ones set; set wins on the same bit
	always_comb
	begin
		mask_next = (mask_reg & ~port.clr_bits) | port.set_bits;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_reg <= event_enable_pkg::MASK_RESET;
		else
			mask_reg <= mask_next;
	end

	assign port.mask = mask_reg;
endmodule : mask_word

/* hdl/submit_gate.sv */
`timescale 1ns/1ps
module submit_gate (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [63:0] latched_event_word,
	input wire logic [63:0] enable_mask,
	input wire logic [63:0] chained_event,
	input wire logic [63:0] manual_event,
	output logic [63:0] submit_event
);
	logic [63:0] submit_reg;
	logic [63:0] submit_next;

	// Latched events need the mask; chained and manual ones do not
	always_comb
	begin
		submit_next = (latched_event_word & enable_mask) | chained_event |
			manual_event;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			submit_reg <= event_enable_pkg::SUBMIT_RESET;
		else
			submit_reg <= submit_next;
	end

	assign submit_event = submit_reg;
endmodule : submit_gate

/* hdl/event_enable_set_clear.sv */
`timescale 1ns/1ps
module event_enable_set_clear (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [63:0] latched_event_word,
	input wire logic [63:0] chained_event,
	input wire logic [63:0] manual_event,
	output logic [63:0] enable_mask,
	output logic [63:0] submit_event
);
	mask_update_if low_if ();
	mask_update_if high_if ();

	logic pready_reg;
	logic pready_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	logic access;
	logic wr_fire;
	logic [31:0] enable_mask_low;
	logic [31:0] enable_mask_high;

	assign enable_mask_low = low_if.mask;
	assign enable_mask_high = high_if.mask;

	mask_word u_mask_low (
		.pclk(pclk),
		.presetn(presetn),
		.port(low_if.owner)
	);

	mask_word u_mask_high (
		.pclk(pclk),
		.presetn(presetn),
		.port(high_if.owner)
	);

	submit_gate u_submit (
		.pclk(pclk),
		.presetn(presetn),
		.latched_event_word(latched_event_word),
		.enable_mask({enable_mask_high, enable_mask_low}),
		.chained_event(chained_event),
		.manual_event(manual_event),
		.submit_event(submit_event)
	);

	// Writes take effect on the edge that completes the access
	always_comb
	begin
		access = psel && penable;
		wr_fire = access && pready_reg && pwrite;
		low_if.set_bits = event_enable_pkg::select_bits(
			wr_fire && (paddr == event_enable_pkg::OFF_SET_LOW),
			pwdata);
		high_if.set_bits = event_enable_pkg::select_bits(
			wr_fire && (paddr == event_enable_pkg::OFF_SET_HIGH),
			pwdata);
		low_if.clr_bits = event_enable_pkg::select_bits(
			wr_fire && (paddr == event_enable_pkg::OFF_CLEAR_LOW),
			pwdata);
		high_if.clr_bits = event_enable_pkg::select_bits(
			wr_fire && (paddr == event_enable_pkg::OFF_CLEAR_HIGH),
			pwdata);
	end

	// One wait state: pready rises on the second access cycle
	always_comb
	begin
		pready_next = access && !pready_reg;
		pslverr_next = access && !pready_reg &&
			!event_enable_pkg::is_mapped(paddr);
		prdata_next = event_enable_pkg::READ_ZERO;
		if (access && !pready_reg && !pwrite)
		begin
			case (paddr)
				event_enable_pkg::OFF_MASK_LOW:
					prdata_next = enable_mask_low;
				event_enable_pkg::OFF_MASK_HIGH:
					prdata_next = enable_mask_high;
				default:
					prdata_next = event_enable_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= event_enable_pkg::READ_ZERO;
		end
		else
		begin
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg <= prdata_next;
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	assign enable_mask = {enable_mask_high, enable_mask_low};

	// Mask registers have no write path; a write there changes nothing

	// Checks
	sequence s_access_wait;
		psel && penable && !pready_reg;
	endsequence

	sequence s_done;
		psel && penable && pready_reg;
	endsequence

	sequence s_write_at(logic [7:0] off);
		s_done ##0 (pwrite && paddr == off);
	endsequence

	// Bus answer and mask write checks
	a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
		s_access_wait |=> pready_reg ##1 !pready_reg)
	else $error("pready not a one-cycle pulse after access start");

	a_set_low_bits: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_SET_LOW) |=>
		enable_mask_low == ($past(enable_mask_low) | $past(pwdata)) &&
		enable_mask_high == $past(enable_mask_high))
	else $error("low set write did not set the written ones");

	a_set_high_bits: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_SET_HIGH) |=>
		enable_mask_high == ($past(enable_mask_high) | $past(pwdata)) &&
		enable_mask_low == $past(enable_mask_low))
	else $error("high set write did not set the written ones");

	a_set_zero_keep: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_write_at(event_enable_pkg::OFF_SET_LOW) ##0 pwdata == 32'h0) |=>
		$stable(enable_mask))
	else $error("zero write to set port changed the mask");

	a_clear_high_bits: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_CLEAR_HIGH) |=>
		enable_mask_high == ($past(enable_mask_high) & ~$past(pwdata)) &&
		enable_mask_low == $past(enable_mask_low))
	else $error("high clear write did not clear the written ones");

	a_clear_low_bits: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_CLEAR_LOW) |=>
		enable_mask_low == ($past(enable_mask_low) & ~$past(pwdata)) &&
		enable_mask_high == $past(enable_mask_high))
	else $error("low clear write did not clear the written ones");

	a_direct_write_ignored: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_done ##0 (pwrite && (paddr == event_enable_pkg::OFF_MASK_LOW ||
		paddr == event_enable_pkg::OFF_MASK_HIGH))) |=>
		$stable(enable_mask))
	else $error("direct write changed the enable mask");

	a_wo_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(s_done ##0 (!pwrite && event_enable_pkg::is_write_only(paddr))) |->
		prdata_reg == event_enable_pkg::READ_ZERO && !pslverr_reg
		##1 $stable(enable_mask))
	else $error("read of a write-only port returned data or had effect");

	a_mask_read_back: assert property (@(posedge pclk) disable iff (!presetn)
		(s_access_wait ##0 (!pwrite &&
		paddr == event_enable_pkg::OFF_MASK_HIGH)) |=>
		prdata_reg == $past(enable_mask_high))
	else $error("mask high read returned wrong data");

	// Event path and bus answer checks
	a_gate_latched: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (submit_event & ~$past(enable_mask) &
		~$past(chained_event) & ~$past(manual_event)) == 64'h0 &&
		(submit_event & $past(latched_event_word) & $past(enable_mask)) ==
		($past(latched_event_word) & $past(enable_mask)))
	else $error("latched event gating by the enable mask is wrong");

	a_bypass_mask: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (submit_event & ($past(chained_event) |
		$past(manual_event))) == ($past(chained_event) | $past(manual_event)))
	else $error("chained or manual event was blocked by the mask");

	a_submit_follows: assert property (@(posedge pclk)
		disable iff (!presetn)
		1'b1 |=> submit_event == (($past(latched_event_word) &
		$past(enable_mask)) | $past(chained_event) | $past(manual_event)))
	else $error("submitted events differ from the gated inputs");

	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(s_access_wait ##0 !event_enable_pkg::is_mapped(paddr)) |=>
		pslverr_reg && pready_reg ##1 !pslverr_reg)
	else $error("unmapped access did not answer with one-cycle error");

	a_ready_needs_access: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(psel && penable) |=> !pready_reg)
	else $error("pready raised without an access");

	a_rdata_idle_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		!pready_reg |-> prdata_reg == event_enable_pkg::READ_ZERO)
	else $error("read data not zero outside the answer cycle");

	a_err_with_ready: assert property (@(posedge pclk)
		disable iff (!presetn)
		pslverr_reg |-> pready_reg)
	else $error("pslverr raised without pready");

	a_mapped_no_error: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_access_wait ##0 event_enable_pkg::is_mapped(paddr)) |=>
		pready_reg && !pslverr_reg)
	else $error("mapped access answered with an error");

	a_mask_low_read: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_access_wait ##0 (!pwrite &&
		paddr == event_enable_pkg::OFF_MASK_LOW)) |=>
		prdata_reg == $past(enable_mask_low))
	else $error("mask low read returned wrong data");

	// Mask update checks
	a_mask_only_by_port: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(psel && penable && pready_reg && pwrite &&
		event_enable_pkg::is_write_only(paddr)) |=> $stable(enable_mask))
	else $error("mask changed without a set or clear write");

	a_read_no_effect: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_done ##0 !pwrite) |=> $stable(enable_mask))
	else $error("read access changed the enable mask");

	a_unmapped_no_effect: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_done ##0 !event_enable_pkg::is_mapped(paddr)) |=>
		$stable(enable_mask))
	else $error("unmapped access changed the enable mask");

	a_set_high_keep: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_write_at(event_enable_pkg::OFF_SET_HIGH) ##0 pwdata == 32'h0)
		|=> $stable(enable_mask))
	else $error("zero write to high set port changed the mask");

	a_clear_low_keep: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_write_at(event_enable_pkg::OFF_CLEAR_LOW) ##0 pwdata == 32'h0)
		|=> $stable(enable_mask))
	else $error("zero write to low clear port changed the mask");

	a_clear_high_keep: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_write_at(event_enable_pkg::OFF_CLEAR_HIGH) ##0 pwdata == 32'h0)
		|=> $stable(enable_mask))
	else $error("zero write to high clear port changed the mask");

	a_set_low_no_fall: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_SET_LOW) |=>
		($past(enable_mask) & ~enable_mask) == 64'h0)
	else $error("low set write cleared a mask bit");

	a_set_high_no_fall: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_write_at(event_enable_pkg::OFF_SET_HIGH) |=>
		($past(enable_mask) & ~enable_mask) == 64'h0)
	else $error("high set write cleared a mask bit");

	a_clear_no_rise: assert property (@(posedge pclk)
		disable iff (!presetn)
		(s_done ##0 (pwrite && (paddr == event_enable_pkg::OFF_CLEAR_LOW ||
		paddr == event_enable_pkg::OFF_CLEAR_HIGH))) |=>
		(enable_mask & ~$past(enable_mask)) == 64'h0)
	else $error("clear write set a mask bit");

endmodule : event_enable_set_clear

/* verif/test_event_enable_set_clear.sv */
`timescale 1ns/1ps
module test_event_enable_set_clear;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seed, ev;
	logic [63:0] lat, chn, man, enable_mask, submit_event, m, exp_sub;
	logic [40:0] tbl [13];
	int err_count, cmp_count;

	event_enable_set_clear i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .latched_event_word(lat), .chained_event(chn),
		.manual_event(man), .enable_mask(enable_mask),
		.submit_event(submit_event));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_rd

	task automatic chk_ev(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_ev

	task automatic test_done;
		$display("Compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	// One APB transfer; keep holds psel for a back-to-back setup
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic keep);
		logic ok;
		int n;
		logic [31:0] rexp;
		ok = (a <= 8'h14) && (a[1:0] == 2'b00);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			test_done;
		end
		penable <= 1'b0;
		chk_rd({31'h0, pslverr}, {31'h0, !ok});
		if (!w)
		begin
			rexp = a == 8'h00 ? m[31:0] : a == 8'h04 ? m[63:32] : 32'h0000_0000;
			chk_rd(prdata, rexp);
		end
		if (w && ok)
			case (a)
				8'h08: m[31:0] = m[31:0] | d;
				8'h0c: m[63:32] = m[63:32] | d;
				8'h10: m[31:0] = m[31:0] & ~d;
				8'h14: m[63:32] = m[63:32] & ~d;
				default: ;
			endcase
		if (!keep)
		begin
			psel <= 1'b0;
			@(posedge pclk);
		end
	endtask : apb

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	always @(posedge pclk)
		if (go)
		begin
			ev = lfsr(ev);
			lat <= {ev, ~ev};
			chn <= {32'h0000_0000, ev & (ev >> 3) & (ev >> 7)};
			man <= {ev & (ev << 5) & (ev >> 9), 32'h0000_0000};
		end

	// Mask and event path checked where outputs are settled
	always @(negedge pclk)
	begin
		chk_ev(enable_mask, m);
		chk_ev(submit_event, exp_sub);
		exp_sub = lat & m | chn | man;
	end

	initial
	begin
		#100000;
		err_count++;
		test_done;
	end

	initial
	begin
		{psel, penable, pwrite, presetn, go} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{lat, chn, man, m, exp_sub} = '0;
		seed = 32'he50e;
		ev = 32'he50e;
		tbl = '{{1'b1, 8'h08, 32'hffff_ffff}, {1'b1, 8'h0c, 32'hffff_ffff},
			{1'b1, 8'h00, 32'h0000_0000}, {1'b1, 8'h04, 32'h0000_0000},
			{1'b0, 8'h04, 32'h0000_0000}, {1'b0, 8'h0c, 32'h0000_0000},
			{1'b1, 8'h14, 32'hffff_ffff}, {1'b0, 8'hfc, 32'h0000_0000},
			{1'b1, 8'h10, 32'hffff_ffff}, {1'b1, 8'h08, 32'h0000_0000},
			{1'b1, 8'h0c, 32'h0000_0000}, {1'b1, 8'h10, 32'h0000_0000},
			{1'b1, 8'h14, 32'h0000_0000}};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		go <= 1'b1;
		// Reset values of every mapped place
		for (int i = 0; i < 6; i++)
			apb(1'b0, 8'(i * 4), 32'h0000_0000, i < 5);
		for (int i = 0; i < 80; i++)
		begin
			seed = lfsr(seed);
			apb(seed[3] | seed[4], 8'(seed[2:0]) << 2, lfsr(seed),
				seed[5]);
		end
		for (int i = 0; i < 13; i++)
			apb(tbl[i][40], tbl[i][39:32], tbl[i][31:0], 1'b0);
		repeat (4) @(posedge pclk);
		test_done;
	end
endmodule : test_event_enable_set_clear
